/* dv/tb.sv */
// self-checking bench for the timer compare and waveform unit
// assumes tcw_unit and its checker are compiled first
`timescale 1ns/10ps
`include "tcw_consts.vh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic timer_tick, ovf_int_ack, match_int_ack;
  logic [7:0] timer_count;
  logic overflow_flag, match_flag, pin_out, pin_oe;
  int err_total, n_tests;
  localparam logic [11:0] CT = `TCW_OFF_CTRL, CN = `TCW_OFF_COUNT;
  localparam logic [11:0] CP = `TCW_OFF_COMPARE, FL = `TCW_OFF_FLAGS;
  tcw_unit tcw_unit_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_tick,
    .ovf_int_ack, .match_int_ack, .timer_count, .overflow_flag,
    .match_flag, .pin_out, .pin_oe);
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'h1, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(a, 1'h0, 32'h0000_0000);
  endtask
  task automatic tk(input int n);
    timer_tick <= 1'h1;
    repeat (n) @(posedge pclk);
    timer_tick <= 1'h0;
    @(posedge pclk);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    rd(FL);
    chk("flags", q, 32'h0000_0000);
    chk("oe", pin_oe, 1'h0);
    rd(12'h020);
    chk("slverr", serr, 1'h1);
  endtask
  task automatic t_normal();
    wr(CP, 32'h0000_0005);
    wr(CT, 32'h0000_0024);
    wr(CN, 32'h0000_00FE);
    tk(2);
    chk("count", timer_count, 32'h0000_0000);
    chk("ovf", overflow_flag, 1'h1);
    ovf_int_ack <= 1'h1;
    @(posedge pclk);
    ovf_int_ack <= 1'h0;
    @(posedge pclk);
    chk("ovf", overflow_flag, 1'h0);
    wr(CN, 32'h0000_0005);
    tk(1);
    chk("match", match_flag, 1'h0);
    wr(CN, 32'h0000_0004);
    tk(2);
    rd(FL);
    chk("flags", q, 32'h0000_0006);
    match_int_ack <= 1'h1;
    @(posedge pclk);
    match_int_ack <= 1'h0;
    @(posedge pclk);
    chk("match", match_flag, 1'h0);
  endtask
  task automatic t_force();
    logic [1:0] cm [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic ex [4] = '{1'h0, 1'h0, 1'h1, 1'h1};
    wr(`TCW_OFF_PORT, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      wr(CT, {26'h0, 2'h1, cm[i], 2'h0});
      rd(FL);
      chk("flags", q, {29'h0, ex[i], 2'h0});
      chk("pin", pin_out, 1'h1 & ex[i] & (cm[i] != 2'h0));
    end
    wr(CT, 32'h0000_001B);
    rd(FL);
    chk("flags", q, 32'h0000_0004);
    chk("pin", pin_out, 1'h1);
  endtask
  task automatic t_ctc();
    wr(CT, 32'h0000_0026);
    wr(CP, 32'h0000_0003);
    wr(CN, 32'h0000_0000);
    tk(4);
    chk("count", timer_count, 32'h0000_0000);
    rd(FL);
    chk("flags", q, 32'h0000_0002);
    wr(CP, 32'h0000_0002);
    wr(CN, 32'h0000_0005);
    tk(251);
    chk("ovf", overflow_flag, 1'h1);
    tk(3);
    chk("count", timer_count, 32'h0000_0000);
  endtask
  task automatic t_fast();
    wr(CT, 32'h0000_002F);
    wr(CP, 32'h0000_0080);
    wr(CN, 32'h0000_00FD);
    wr(FL, 32'h0000_0001);
    tk(2);
    chk("ovf", overflow_flag, 1'h1);
    tk(1);
    chk("count", timer_count, 32'h0000_0000);
    wr(CP, 32'h0000_0010);
    tk(32);
    rd(FL);
    chk("state", q[2], 1'h0);
    tk(97);
    rd(FL);
    chk("state", q[2], 1'h1);
    tk(127);
    rd(FL);
    chk("state", q[2], 1'h0);
    tk(17);
    rd(FL);
    chk("state", q[2], 1'h1);
  endtask
  task automatic t_edge();
    wr(CT, 32'h0000_0027);
    wr(CN, 32'h0000_000F);
    tk(2);
    chk("pin", pin_out, 1'h0);
    wr(CP, 32'h0000_0011);
    tk(1);
    chk("pin", pin_out, 1'h0);
    wr(CT, 32'h0000_002B);
    wr(CP, 32'h0000_0000);
    wr(CN, 32'h0000_00FE);
    tk(2);
    chk("pin", pin_out, 1'h1);
    tk(1);
    chk("pin", pin_out, 1'h0);
    wr(CT, 32'h0000_0022);
    wr(CP, 32'h0000_0003);
    wr(CN, 32'h0000_0001);
    wr(FL, 32'h0000_0003);
    tk(3);
    rd(FL);
    chk("flags", q, 32'h0000_0002);
    wr(CT, 32'h0000_0026);
    tk(4);
    chk("pin", pin_out, 1'h1);
    tk(1);
    wr(FL, 32'h0000_0002);
    wr(CT, 32'h0000_0036);
    chk("count", timer_count, 32'h0000_0001);
    chk("match", match_flag, 1'h0);
    chk("pin", pin_out, 1'h0);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    final_report();
  end
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    timer_tick = 1'h0;
    ovf_int_ack = 1'h0;
    match_int_ack = 1'h0;
    err_total = 0;
    n_tests = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_normal();
    t_force();
    t_ctc();
    t_fast();
    t_edge();
    final_report();
  end
endmodule // tb

/* dv/tcw_unit_asserts.sv */
// port-level checker for the timer compare and waveform unit
// assumes binding into tcw_unit; everything runs on pclk
`timescale 1ns/10ps
`include "tcw_consts.vh"
module tcw_unit_asserts (
  // apb
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // timer
  input logic timer_tick,
  input logic ovf_int_ack,
  input logic match_int_ack,
  input logic [7:0] timer_count,
  input logic overflow_flag,
  input logic match_flag,
  // pin
  input logic pin_out,
  input logic pin_oe
);
  logic [5:0] ctl;
  logic [1:0] prt;
  logic [7:0] wd;
  wire wr = psel & penable & pwrite;
  wire cwr = wr && paddr == `TCW_OFF_COUNT;
  wire run = timer_tick & ctl[5] & !cwr;
  wire [1:0] md = ctl[1:0];
  // shadow of control and port bits seen on the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 6'h00;
      prt <= 2'h0;
      wd <= 8'h00;
    end else begin
      wd <= pwdata[7:0];
      if (wr && paddr == `TCW_OFF_CTRL) ctl <= pwdata[5:0];
      if (wr && paddr == `TCW_OFF_PORT) prt <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cnt_hold: assert property (!timer_tick && !cwr |=>
    $stable(timer_count)) else $error("count moved without tick");
  a_cnt_write: assert property (cwr |=> timer_count == wd)
    else $error("count write lost");
  a_norm_inc: assert property (run && md == `TCW_WGM_NORMAL |=>
    timer_count == $past(timer_count) + 8'h01) else $error("no step");
  a_norm_ovf: assert property (run && md == `TCW_WGM_NORMAL &&
    timer_count == 8'hFF |=> overflow_flag) else $error("no wrap flag");
  a_fast_wrap: assert property (run && md == `TCW_WGM_FAST &&
    timer_count == 8'hFF |=> timer_count == 8'h00) else $error("no wrap");
  a_fast_ovf: assert property (run && md == `TCW_WGM_FAST &&
    timer_count == 8'hFE |=> overflow_flag) else $error("no max flag");
  a_port_val: assert property (ctl[3:2] == 2'h0 |->
    pin_out == prt[0]) else $error("port value not passed");
  a_port_dir: assert property (pin_oe == prt[1])
    else $error("direction wrong");
  a_match_clr: assert property (match_int_ack && !timer_tick |=>
    !match_flag) else $error("match flag kept");
  a_ovf_keep: assert property (overflow_flag && !ovf_int_ack && !wr
    |=> overflow_flag) else $error("overflow flag lost");
  cover property (cwr);
  cover property ($rose(overflow_flag));
  cover property ($rose(match_flag));
endmodule // tcw_unit_asserts
bind tcw_unit tcw_unit_asserts tcw_unit_asserts_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .timer_tick, .ovf_int_ack, .match_int_ack, .timer_count,
  .overflow_flag, .match_flag, .pin_out, .pin_oe);

/* hw/tcw_consts.vh */
// constants for the timer compare and waveform unit
// assumes inclusion by bare name from design files
`ifndef TCW_CONSTS_VH
`define TCW_CONSTS_VH
// ******************************
// register offsets (byte addresses)
// ******************************
`define TCW_OFF_CTRL 12'h000
`define TCW_OFF_COUNT 12'h004
`define TCW_OFF_COMPARE 12'h008
`define TCW_OFF_FLAGS 12'h00C
`define TCW_OFF_PORT 12'h010
// ******************************
// control, flag and port field positions
// ******************************
`define TCW_CTRL_WGM_LO 0
`define TCW_CTRL_COM_LO 2
`define TCW_CTRL_FORCE 4
`define TCW_CTRL_TICK_EN 5
`define TCW_FLAG_OVF 0
`define TCW_FLAG_MATCH 1
`define TCW_FLAG_OSTATE 2
`define TCW_PORT_OUT 0
`define TCW_PORT_DIR 1
// ******************************
// modes and values
// ******************************
`define TCW_WGM_NORMAL 2'h0
`define TCW_WGM_PHASE 2'h1
`define TCW_WGM_CTC 2'h2
`define TCW_WGM_FAST 2'h3
`define TCW_COM_OFF 2'h0
`define TCW_COM_TOGGLE 2'h1
`define TCW_COM_CLEAR 2'h2
`define TCW_COM_SET 2'h3
`define TCW_CNT_MAX 8'hFF
`define TCW_CNT_BOTTOM 8'h00
`endif

/* hw/tcw_unit.v */
// compare-output and waveform logic of an 8-bit timer/counter, APB slave
// assumes: timer_tick is a one-cycle enable from a prescaler on pclk
// How it works
// - a software count write blocks every compare match on the next tick
// - output state keeps its value when waveform selection changes
// - output action bits act unbuffered from the next match on
// - reset clears the output state to zero
// - nonzero action replaces port value; direction still from port bit
// - port override is the same in every waveform mode
// - action zero leaves output state alone on matches
// - force strobe applies the action at once in non-PWM modes
// - count sequence depends on waveform selection only
// - mode zero counts up, wraps 0xFF to 0x00, writable any time
// - normal mode sets overflow on the tick count becomes zero
// - mode two clears the count on match, compare is top
// - ctc compare written directly; below count means wrap first
// - ctc with action one toggles the output state on each match
// - ctc sets overflow on the rollover from max to zero
// - mode three counts zero to 0xFF then clears next tick
// - fast pwm two clears on match, sets at zero; three inverse
// - fast pwm sets overflow each time count reaches max
// - fast pwm compare zero spikes, compare max holds level
// - fast pwm action one toggles per match, buffering stays
// - compare double buffered in pwm, loaded at top; else direct
// - real match sets match flag on next tick; forced one does not
// - match flag cleared by interrupt acknowledge or write of one
`timescale 1ns/10ps
`include "tcw_consts.vh"

module tcw_unit (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // timer side
  input wire timer_tick,
  input wire ovf_int_ack,
  input wire match_int_ack,
  output reg [7:0] timer_count,
  output reg overflow_flag,
  output reg match_flag,
  // port pin
  output wire pin_out,
  output wire pin_oe
);

  // ******************************
  // bus decode
  // ******************************
  wire wr_en;
  wire rd_en;
  wire sel_ctrl;
  wire sel_count;
  wire sel_compare;
  wire sel_flags;
  wire sel_port;
  wire mapped;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign sel_ctrl = (paddr == `TCW_OFF_CTRL);
  assign sel_count = (paddr == `TCW_OFF_COUNT);
  assign sel_compare = (paddr == `TCW_OFF_COMPARE);
  assign sel_flags = (paddr == `TCW_OFF_FLAGS);
  assign sel_port = (paddr == `TCW_OFF_PORT);
  assign mapped = sel_ctrl | sel_count | sel_compare | sel_flags | sel_port;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ******************************
  // control state
  // ******************************
  reg [1:0] waveform_selection;
  reg [1:0] output_action_select;
  reg tick_enable;
  reg [7:0] compare_value;
  reg [7:0] compare_buffer;
  reg compare_output_state;
  reg port_value;
  reg port_dir;
  reg block_match;

  wire pwm_mode;
  wire force_match_strobe;
  wire count_write;
  wire tick;
  wire flags_write;

  assign pwm_mode = waveform_selection[0];
  assign force_match_strobe = wr_en & sel_ctrl & pwdata[`TCW_CTRL_FORCE];
  assign count_write = wr_en & sel_count;
  assign flags_write = wr_en & sel_flags;
  assign tick = timer_tick & tick_enable;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_selection <= `TCW_WGM_NORMAL;
      output_action_select <= `TCW_COM_OFF;
      tick_enable <= 1'b0;
      port_value <= 1'b0;
      port_dir <= 1'b0;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        // mode change touches no output state
        waveform_selection <= pwdata[`TCW_CTRL_WGM_LO+1:`TCW_CTRL_WGM_LO];
        // unbuffered: governs the very next match
        output_action_select <= pwdata[`TCW_CTRL_COM_LO+1:`TCW_CTRL_COM_LO];
        tick_enable <= pwdata[`TCW_CTRL_TICK_EN];
      end
      if (sel_port) begin
        port_value <= pwdata[`TCW_PORT_OUT];
        port_dir <= pwdata[`TCW_PORT_DIR];
      end
    end
  end

  // ******************************
  // compare value buffering
  // ******************************
  wire at_top_pwm;
  assign at_top_pwm = tick & (timer_count == `TCW_CNT_MAX);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value <= 8'h00;
      compare_buffer <= 8'h00;
    end else begin
      if (wr_en && sel_compare) begin
        compare_buffer <= pwdata[7:0];
      end
      if (!pwm_mode) begin
        // direct write in normal and ctc
        if (wr_en && sel_compare) begin
          compare_value <= pwdata[7:0];
        end
      end else if (at_top_pwm) begin
        // buffered value loads at top of the count
        compare_value <= (wr_en && sel_compare) ? pwdata[7:0] :
          compare_buffer;
      end
    end
  end

  // ******************************
  // match detection
  // ******************************
  wire match;
  assign match = tick & ~block_match &
    (timer_count == compare_value);

  // a count write blocks matches for the following tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_match <= 1'b0;
    end else if (count_write) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // ******************************
  // counter
  // ******************************
  reg [7:0] next_count;
  always @* begin
    next_count = timer_count;
    if (tick) begin
      // sequence set by waveform selection only
      case (waveform_selection)
        `TCW_WGM_CTC: begin
          if (match) begin
            next_count = `TCW_CNT_BOTTOM;
          end else begin
            next_count = timer_count + 8'h01;
          end
        end
        `TCW_WGM_FAST: begin
          next_count = timer_count + 8'h01; // wraps after max
        end
        default: begin
          next_count = timer_count + 8'h01;
        end
      endcase
    end
    if (count_write) begin
      next_count = pwdata[7:0]; // software write has priority
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= 8'h00;
    end else begin
      timer_count <= next_count;
    end
  end

  // ******************************
  // flags
  // ******************************
  wire ovf_event;
  wire rollover;
  assign rollover = tick & (timer_count == `TCW_CNT_MAX) & ~count_write;
  // normal/ctc: tick where count rolls from max to zero; fast: reaches max
  assign ovf_event = (waveform_selection == `TCW_WGM_FAST) ?
    (tick & ~count_write & (timer_count == 8'hFE)) :
    rollover;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
      match_flag <= 1'b0;
    end else begin
      // set wins over clear
      if (ovf_event) begin
        overflow_flag <= 1'b1;
      end else if (ovf_int_ack ||
          (flags_write && pwdata[`TCW_FLAG_OVF])) begin
        overflow_flag <= 1'b0;
      end
      if (match) begin
        match_flag <= 1'b1; // forced match never lands here
      end else if (match_int_ack ||
          (flags_write && pwdata[`TCW_FLAG_MATCH])) begin
        match_flag <= 1'b0;
      end
    end
  end

  // ******************************
  // waveform generator
  // ******************************
  reg next_ostate;
  wire restart;
  wire forced;
  wire [1:0] force_action;
  assign restart = rollover;
  // strobe, mode and action come in one control write, so the strobe
  // must use the mode and action written with it, not the old ones
  assign force_action = pwdata[`TCW_CTRL_COM_LO+1:`TCW_CTRL_COM_LO];
  assign forced = force_match_strobe &
    ~pwdata[`TCW_CTRL_WGM_LO];

  always @* begin
    next_ostate = compare_output_state;
    if (forced) begin
      // a real match in the same cycle is absorbed by the forced one
      case (force_action)
        `TCW_COM_TOGGLE: next_ostate = ~compare_output_state;
        `TCW_COM_CLEAR: next_ostate = 1'b0;
        `TCW_COM_SET: next_ostate = 1'b1;
        default: next_ostate = compare_output_state;
      endcase
    end else if (!pwm_mode) begin
      if (match) begin
        case (output_action_select)
          `TCW_COM_TOGGLE: next_ostate = ~compare_output_state;
          `TCW_COM_CLEAR: next_ostate = 1'b0;
          `TCW_COM_SET: next_ostate = 1'b1;
          default: next_ostate = compare_output_state;
        endcase
      end
    end else if (waveform_selection == `TCW_WGM_FAST) begin
      case (output_action_select)
        `TCW_COM_TOGGLE: begin
          if (match) begin
            next_ostate = ~compare_output_state;
          end
        end
        `TCW_COM_CLEAR: begin
          // match wins over restart so compare max holds the output low
          if (match) begin
            next_ostate = 1'b0;
          end else if (restart) begin
            next_ostate = 1'b1;
          end
        end
        `TCW_COM_SET: begin
          if (match) begin
            next_ostate = 1'b1;
          end else if (restart) begin
            next_ostate = 1'b0;
          end
        end
        default: next_ostate = compare_output_state;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_state <= 1'b0;
    end else begin
      compare_output_state <= next_ostate;
    end
  end

  // ******************************
  // port override, mode independent
  // ******************************
  assign pin_out = (output_action_select != `TCW_COM_OFF) ?
    compare_output_state : port_value;
  assign pin_oe = port_dir;

  // ******************************
  // read data
  // ******************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (sel_ctrl) begin
        prdata[5:0] <= {tick_enable, 1'b0, output_action_select,
          waveform_selection};
      end else if (sel_count) begin
        prdata[7:0] <= timer_count;
      end else if (sel_compare) begin
        prdata[7:0] <= pwm_mode ? compare_buffer : compare_value;
      end else if (sel_flags) begin
        prdata[2:0] <= {compare_output_state, match_flag, overflow_flag};
      end else if (sel_port) begin
        prdata[1:0] <= {port_dir, port_value};
      end
    end
  end

endmodule // tcw_unit
